// ===== bench/tfs_framer_sync_tb_top.sv
// Purpose: Self-checking bench for the framer, coder and synchronizer.
// Assumes: Loopback line model; frame strobes from a free counter.
// Notes:   Inputs change on the falling edge.
`timescale 1ns/10ps
module tfs_framer_sync_tb_top;
  import tfs_pkg::*;
  // ****
  // Stimulus and checks
  // ****
  localparam logic [11:0] FPAT = 12'h3b1;
  logic clk = 1'b0, rst_n = 1'b0, txSerialIn = 1'b1, rxResyncReset_n = 1'b1;
  tfs_cfg_t    cfg = '0;
  tfs_sig_t    txSigIn = 4'h4;
  logic [23:0] clearChannels = 24'h00_0000;
  logic [1:0]  mode = 2'h0;
  logic txPositiveRail, txNegativeRail, rxPositiveRail, rxNegativeRail;
  logic rxDataOut, rxB8zsSeen, rxBipolarError, rxCarrierLoss, syncLossFlag;
  logic rxSignalingFrameInd, rxMultiframePulse;
  int bitPos = 0, frameNo = 0, cyc = 0, n_fail = 0, n_compared = 0;
  wire txFrameSyncIn = (bitPos == 0);
  wire txMultiframeSyncIn = (bitPos == 0) && (frameNo == 0);
  always #5 clk = ~clk;
  tfs_framer_sync u_tfs_framer_sync (.clk, .rst_n, .cfg, .clearChannels,
    .txSerialIn, .txFrameSyncIn, .txMultiframeSyncIn, .txLinkIn(1'b0),
    .txSigIn, .rxPositiveRail, .rxNegativeRail, .rxResyncReset_n,
    .txPositiveRail, .txNegativeRail, .rxDataOut, .rxB8zsSeen, .rxBipolarError,
    .rxCarrierLoss, .syncLossFlag, .rxSignalingFrameInd, .rxMultiframePulse,
    .rxFramingErrorOut(), .rxLinkBitsOut());
  tfs_line_model u_tfs_line_model (.clk, .rst_n, .mode, .txPos(txPositiveRail),
    .txNeg(txNegativeRail), .rxPos(rxPositiveRail), .rxNeg(rxNegativeRail));
  always @(negedge clk) begin
    cyc = cyc + 1;
    if (cyc == 99000) begin
      n_fail++;
      tally_and_finish();
    end
    bitPos = (bitPos == 192) ? 0 : bitPos + 1;
    if (bitPos == 0) frameNo = (frameNo == 11) ? 0 : frameNo + 1;
  end
  task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s exp %0h got %0h", what, exp, got);
    end
  endtask
  task markAt(input int f, input int p, output logic m);
    do begin @(negedge clk); #1; end while (!(frameNo == f && bitPos == p + 10));
    m = txPositiveRail | txNegativeRail;
  endtask
  task t_frame;
    logic m;
    wait (frameNo == 1);
    for (int f = 0; f < 12; f++) begin
      markAt(f, 0, m);
      chk("F bit", 8'(FPAT[f]), 8'(m));
      if (f == 5 || f == 11) begin
        markAt(f, 8, m);
        chk("robbed", 8'(f == 11), 8'(m));
      end
    end
    clearChannels = 24'h00_0001;
    markAt(5, 8, m);
    chk("clear ch", 8'h01, 8'(m));
  endtask
  task t_sync;
    for (int k = 0; k < 80000 && syncLossFlag !== 1'b0; k++) @(negedge clk);
    chk("sync", 8'h00, 8'(syncLossFlag));
    for (int k = 0; k < 2400 && rxSignalingFrameInd !== 1'b1; k++) @(negedge clk);
    chk("sig frame", 8'h01, 8'(rxSignalingFrameInd));
  endtask
  task t_resync;
    cfg.resync = 1'b1;
    repeat (6) @(negedge clk);
    chk("resync", 8'h01, 8'(syncLossFlag));
    cfg.resync = 1'b0;
    rxResyncReset_n = 1'b0;
    repeat (20) @(negedge clk);
    chk("rst hold", 8'h00, 8'(rxMultiframePulse | rxSignalingFrameInd));
    rxResyncReset_n = 1'b1;
  endtask
  task t_rxcode(input logic en);
    int seen, ones, errs, run, maxRun;
    seen = 0; ones = 0; errs = 0; run = 0; maxRun = 0;
    cfg.b8zsEnable = en;
    txSerialIn = !en;
    mode = 2'h2;
    repeat (40) @(negedge clk);
    repeat (64) begin
      @(negedge clk); #1;
      seen += rxB8zsSeen; ones += rxDataOut; errs += rxBipolarError;
      run = (txPositiveRail | txNegativeRail) ? 0 : run + 1;
      if (run > maxRun) maxRun = run;
    end
    chk("b8zs seen", 8'h08, 8'(seen));
    chk("rx ones", 8'(!en), 8'(ones != 0));
    chk("bpv", 8'(!en), 8'(errs != 0));
    chk("tx run", 8'h01, 8'(maxRun < 8));
  endtask
  task t_carrier;
    mode = 2'h1;
    repeat (CARRIER_ZERO + 8) @(negedge clk);
    chk("carrier", 8'h01, 8'(rxCarrierLoss));
  endtask
  task tally_and_finish;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    t_frame();
    t_sync();
    t_resync();
    t_rxcode(1'b0);
    t_rxcode(1'b1);
    t_carrier();
    tally_and_finish();
  end
endmodule // tfs_framer_sync_tb_top

// ===== bench/tfs_line_model.sv
// Purpose: Line interface model: loopback, silent line or code words.
// Assumes: Mode 0 loopback, 1 silent, 2 repeated substitution words.
// Notes:   Rails change on the falling edge.
`timescale 1ns/10ps
module tfs_line_model (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic [1:0] mode,
  input wire logic       txPos,
  input wire logic       txNeg,
  output logic           rxPos,
  output logic           rxNeg
);
  // ****
  // Line drive
  // ****
  logic [2:0] slot;
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) slot <= 3'h0;
    else slot <= slot + 3'h1;
  end
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxPos <= 1'b0;
      rxNeg <= 1'b0;
    end else begin
      rxPos <= (mode == 2'h0) ? txPos : (mode == 2'h2) & slot[1:0] == 2'h3;
      rxNeg <= (mode == 2'h0) ? txNeg : (mode == 2'h2) & (slot == 4 || slot == 6);
    end
  end
endmodule // tfs_line_model

// ===== bench/tfs_props.sv
// Purpose: Port assertions for the framer, coder and synchronizer.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to every instance of the top module.
`timescale 1ns/10ps
module tfs_props #(
  parameter int CARRIER_ZEROS = 32
) (
  input wire logic              clk,
  input wire logic              rst_n,
  input wire tfs_pkg::tfs_cfg_t cfg,
  input wire logic              txFrameSyncIn,
  input wire logic              txMultiframeSyncIn,
  input wire logic              rxPositiveRail,
  input wire logic              rxNegativeRail,
  input wire logic              rxResyncReset_n,
  input wire logic              txPositiveRail,
  input wire logic              txNegativeRail,
  input wire logic              rxB8zsSeen,
  input wire logic              rxCarrierLoss,
  input wire logic              syncLossFlag,
  input wire logic              rxSignalingFrameInd,
  input wire logic              rxMultiframePulse
);
  import tfs_pkg::*;
  // ****
  // Helpers and checks
  // ****
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [1:0] lastMark;
  logic [7:0] zeroRun;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lastMark <= 2'h0;
    else if (txPositiveRail | txNegativeRail) lastMark <= {1'b1, txPositiveRail};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) zeroRun <= 8'h00;
    else if (rxPositiveRail | rxNegativeRail) zeroRun <= 8'h00;
    else if (zeroRun != 8'hff) zeroRun <= zeroRun + 8'h01;
  end
  a_rails_excl:
    assert property (!(txPositiveRail && txNegativeRail)) else $error("Both rails");
  a_ami_alt:
    assert property (disable iff (!rst_n || cfg.b8zsEnable)
      lastMark[1] && (txPositiveRail || txNegativeRail)
      |-> txPositiveRail != lastMark[0]) else $error("Mark polarity");
  a_tx_latency:
    assert property (txFrameSyncIn && txMultiframeSyncIn &&
      !cfg.extendedSuperframeMode |-> ##10 (txPositiveRail || txNegativeRail))
      else $error("Frame bit late");
  a_resync_go:
    assert property ($rose(cfg.resync) |-> ##[1:4] syncLossFlag)
      else $error("No search");
  a_search_sigfr:
    assert property (syncLossFlag && $past(syncLossFlag) |-> !rxSignalingFrameInd)
      else $error("Indicator in search");
  a_carrier_set:
    assert property (zeroRun >= CARRIER_ZEROS + 2 |-> rxCarrierLoss)
      else $error("Carrier loss missed");
  a_carrier_clr:
    assert property (zeroRun < CARRIER_ZEROS - 2 &&
      $past(zeroRun) < CARRIER_ZEROS - 2 |-> !rxCarrierLoss)
      else $error("Carrier loss early");
  a_rst_hold:
    assert property (!rxResyncReset_n && !$past(rxResyncReset_n)
      |-> !rxMultiframePulse && !rxSignalingFrameInd) else $error("Timing runs");
  c_synced: cover property ($fell(syncLossFlag));
  c_b8zs: cover property (rxB8zsSeen);
  c_resync: cover property ($rose(cfg.resync));
endmodule // tfs_props
bind tfs_framer_sync tfs_props #(.CARRIER_ZEROS(CARRIER_ZEROS)) u_tfs_props (
  .clk, .rst_n, .cfg, .txFrameSyncIn, .txMultiframeSyncIn, .rxPositiveRail,
  .rxNegativeRail, .rxResyncReset_n, .txPositiveRail, .txNegativeRail,
  .rxB8zsSeen, .rxCarrierLoss, .syncLossFlag, .rxSignalingFrameInd,
  .rxMultiframePulse);

// ===== shared/tfs_pkg.sv
// Purpose: Shared constants and types for the T1 framer, coder and sync.
// Assumes: One line bit per clock on both transmit and receive sides.
// Notes:   Multiframe-based CRC timing derived from the ESF frame length.
package tfs_pkg;
  // ************************************************************
  // Frame geometry
  // ************************************************************
  localparam int FRAME_BITS    = 193;
  localparam int CHAN_BITS     = 8;
  localparam int SF_FRAMES_12  = 12;
  localparam int SF_FRAMES_24  = 24;
  localparam int FRAME_US      = 125;
  localparam int MFRAME_US     = SF_FRAMES_24 * FRAME_US;

  // ************************************************************
  // Framing patterns, first bit in bit 0
  // ************************************************************
  localparam logic [5:0] FS_SEQ   = 6'h1c;
  localparam logic [5:0] FPS_SEQ  = 6'h34;

  // ************************************************************
  // Line coding
  // ************************************************************
  localparam int         TX_DELAY     = 10;
  localparam logic [7:0] SUB_MARKS    = 8'h1b;
  localparam logic [7:0] SUB_VIOL     = 8'h12;
  localparam logic [7:0] SUB_TAIL     = 8'hfe;
  localparam int         CARRIER_ZERO = 32;

  // ************************************************************
  // Synchronizer
  // ************************************************************
  localparam int         SYNC_LONG    = 24;
  localparam int         SYNC_SHORT   = 10;
  localparam int         OOF_WINDOW   = 4;
  localparam int         OOF_LIMIT    = 2;
  localparam int         CRC_FIRST_MS = 9;
  localparam int         CRC_NEXT_MS  = 3;
  localparam int         EMUL_MS      = 24;
  localparam int         CRC_FIRST_MF = CRC_FIRST_MS * 1000 / MFRAME_US;
  localparam int         CRC_NEXT_MF  = CRC_NEXT_MS * 1000 / MFRAME_US;
  localparam int         EMUL_MF      = EMUL_MS * 1000 / MFRAME_US;
  localparam int         CRC_TRIES    = 3;
  localparam logic [5:0] CRC_POLY     = 6'h03;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } tfs_sig_t;

  typedef struct packed {
    logic extendedSuperframeMode;
    logic bit7Stuff;
    logic b8zsEnable;
    logic yellowAlarmMode;
    logic syncTime;
    logic syncEnable;
    logic syncCriteria;
    logic resync;
  } tfs_cfg_t;

  typedef enum logic [2:0] {
    ST_SYNC,
    ST_HUNT,
    ST_LOAD,
    ST_CONFIRM,
    ST_CRC
  } tfs_state_t;
endpackage

// ===== verilog/tfs_framer_sync.sv
// Purpose: T1 framing insertion, AMI/B8ZS/bit-7 coding and receive sync.
// Assumes: Each clk is one line bit; rails and serial data are synchronous.
// Notes:   Receive hunt checks one candidate at a time by slipping.
//
// Summary of operation
// - 12-frame mode sends Ft 101010 and Fs 001110 repeating.
// - Signaling A in frame 6, B in frame 12, bit 8 unless clear.
// - Ones become alternating-polarity pulses, zeros no pulse.
// - Bit-7 stuffing forces bit 7 high in all-zero channels.
// - B8ZS replaces eight zeros, 000VB0VB, positive case shown positive.
// - Violations inside a B8ZS word are not errors when enabled.
// - Received B8ZS words become eight zeros when enabled.
// - Received B8ZS words are always flagged.
// - Serial input reaches the line rails ten clocks later.
// - During search output timing stays, signaling-frame indicator low.
// - Single candidate loads at multiframe start; sync loss clears frame later.
// - Sync-time bit selects 24 or 10 good framing bits.
// - Rising resync bit starts a search at once, any state.
// - Auto resync on out-of-frame or 32 zeros when sync-enable clear.
// - Out-of-frame when 2 of last 4 framing bits wrong.
// - Sync-enable set: resync only by bit or reset rising edge.
// - ESF with criteria set needs CRC match; three failures restart.
// - First CRC check 9 ms after load, then every 3 ms.
// - After about 24 ms of search, ESF candidates get CRC tested.
// - 12-frame criteria set checks Ft and Fs; yellow skips frame 12.
// - 12-frame criteria clear syncs on Ft; multiframe needs valid Fs.
// - Framing error flags S-bit mismatches; S-bits go to link output.
// - Frame is one F bit then 24 channels, MSB first.
// - Superframe is 12 frames or 24 frames in extended mode.
`timescale 1ns/10ps
module tfs_framer_sync #(
  parameter int CARRIER_ZEROS = tfs_pkg::CARRIER_ZERO
) (
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire tfs_pkg::tfs_cfg_t cfg,
  input  wire logic [23:0]     clearChannels,
  input  wire logic            txSerialIn,
  input  wire logic            txFrameSyncIn,
  input  wire logic            txMultiframeSyncIn,
  input  wire logic            txLinkIn,
  input  wire tfs_pkg::tfs_sig_t txSigIn,
  input  wire logic            rxPositiveRail,
  input  wire logic            rxNegativeRail,
  input  wire logic            rxResyncReset_n,
  output logic                 txPositiveRail,
  output logic                 txNegativeRail,
  output logic                 rxDataOut,
  output logic                 rxB8zsSeen,
  output logic                 rxBipolarError,
  output logic                 rxCarrierLoss,
  output logic                 syncLossFlag,
  output logic                 rxSignalingFrameInd,
  output logic                 rxMultiframePulse,
  output logic                 rxFramingErrorOut,
  output logic                 rxLinkBitsOut
);
  import tfs_pkg::*;

  generate
    if (CARRIER_ZEROS < 1 || CARRIER_ZEROS > 255) begin : g_bad
      $error("CARRIER_ZEROS out of range");
    end
  endgenerate

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [5:0] crc6Step(input logic [5:0] c,
                                          input logic b);
    crc6Step = {c[4:0], 1'b0} ^ ((c[5] ^ b) ? CRC_POLY : 6'h00);
  endfunction

  function automatic logic [4:0] lastFrame(input logic esf);
    lastFrame = esf ? 5'(SF_FRAMES_24 - 1) : 5'(SF_FRAMES_12 - 1);
  endfunction

  // Returns {check, expected} for the F bit of frame f (0-based)
  function automatic logic [1:0] fExpect(input logic esf,
                                         input logic [4:0] f,
                                         input logic fsToo,
                                         input logic yel);
    if (esf) begin
      fExpect = {f[1:0] == 2'h3, FPS_SEQ[f[4:2]]};
    end else if (!f[0]) begin
      fExpect = {1'b1, ~f[1]};
    end else begin
      fExpect = {fsToo && !(yel && f == 5'(SF_FRAMES_12 - 1)),
                 FS_SEQ[f[3:1]]};
    end
  endfunction

  function automatic logic sigFrame(input logic esf, input logic [4:0] f);
    sigFrame = (f == 5'h05) || (f == 5'h0b)
               || (esf && (f == 5'h11 || f == 5'h17));
  endfunction

  // ************************************************************
  // Transmit timing and insertion
  // ************************************************************
  logic [7:0] txBitCnt;
  logic [4:0] txFrameCnt;
  logic [7:0] txPos;
  logic [4:0] txFrm;
  logic       txChEnd;
  logic [4:0] txChan;
  logic       txFbit;
  logic       txSigBit;
  logic       txIns;
  logic [7:0] txWin;
  logic       txSubst;
  logic       txMfEnd;
  logic [5:0] txCrc;
  logic [5:0] txCrcPrev;
  logic [7:0] txSh;
  logic [7:0] txViolSh;
  logic       txLastPol;
  logic       amiPos;
  logic       amiNeg;
  logic       esf;
  logic [1:0] txFexp;

  assign esf = cfg.extendedSuperframeMode;

  always_comb begin
    txPos    = txFrameSyncIn ? 8'h00 : txBitCnt;
    txFrm    = txMultiframeSyncIn ? 5'h00 : txFrameCnt;
    txChEnd  = (txPos != 8'h00) && (txPos[2:0] == 3'h0);
    txChan   = 5'((txPos - 8'h01) >> 3);
    txMfEnd  = (txPos == 8'(FRAME_BITS - 1)) && (txFrm == lastFrame(esf));
    txFexp   = fExpect(1'b0, txFrm, 1'b1, 1'b0);
    if (!esf) begin
      txFbit = txFexp[0];
    end else if (!txFrm[0]) begin
      txFbit = txLinkIn;
    end else if (txFrm[1:0] == 2'h1) begin
      txFbit = txCrcPrev[3'(5) - 3'(txFrm[4:2])];
    end else begin
      txFbit = FPS_SEQ[txFrm[4:2]];
    end
    case (txFrm)
      5'h05:   txSigBit = txSigIn.a;
      5'h0b:   txSigBit = txSigIn.b;
      5'h11:   txSigBit = txSigIn.c;
      default: txSigBit = txSigIn.d;
    endcase
    if (txPos == 8'h00) begin
      txIns = txFbit;
    end else if (txChEnd && sigFrame(esf, txFrm) && !clearChannels[txChan]) begin
      txIns = txSigBit;
    end else begin
      txIns = txSerialIn;
    end
    txWin = {txSh[6:0], txIns};
    if (cfg.bit7Stuff && txChEnd && txWin == 8'h00) begin
      txWin[1] = 1'b1;
    end
    txSubst = cfg.b8zsEnable && (txWin == 8'h00);
    if (txSubst) begin
      txWin = SUB_MARKS;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txBitCnt   <= 8'h00;
      txFrameCnt <= 5'h00;
    end else begin
      txBitCnt   <= (txPos == 8'(FRAME_BITS - 1)) ? 8'h00 : txPos + 8'h01;
      if (txPos == 8'(FRAME_BITS - 1)) begin
        txFrameCnt <= (txFrm == lastFrame(esf)) ? 5'h00 : txFrm + 5'h01;
      end else begin
        txFrameCnt <= txFrm;
      end
    end
  end

  // CRC-6 over the multiframe with F bits taken as one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txCrc     <= 6'h00;
      txCrcPrev <= 6'h00;
    end else if (txMfEnd) begin
      txCrc     <= 6'h00;
      txCrcPrev <= crc6Step(txCrc, txIns);
    end else begin
      txCrc     <= crc6Step(txCrc, (txPos == 8'h00) ? 1'b1 : txIns);
    end
  end

  // ************************************************************
  // Transmit coder: 8-stage window, AMI stage, output stage
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txSh     <= 8'h00;
      txViolSh <= 8'h00;
    end else begin
      txSh     <= txWin;
      txViolSh <= txSubst ? SUB_VIOL : {txViolSh[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txLastPol      <= 1'b0;
      amiPos         <= 1'b0;
      amiNeg         <= 1'b0;
      txPositiveRail <= 1'b0;
      txNegativeRail <= 1'b0;
    end else begin
      amiPos <= 1'b0;
      amiNeg <= 1'b0;
      if (txSh[7]) begin
        // Violation repeats last polarity; mirrored after negative
        amiPos    <= txViolSh[7] ? txLastPol : ~txLastPol;
        amiNeg    <= txViolSh[7] ? ~txLastPol : txLastPol;
        txLastPol <= txViolSh[7] ? txLastPol : ~txLastPol;
      end
      txPositiveRail <= amiPos;
      txNegativeRail <= amiNeg;
    end
  end

  // ************************************************************
  // Receive decoder
  // ************************************************************
  logic [7:0] rxPosSh;
  logic [7:0] rxNegSh;
  logic [7:0] rxSubSh;
  logic [7:0] rxMk;
  logic       rxLastPol;
  logic       rxDet;
  logic       rxSubNow;
  logic       rxBit;
  logic [7:0] zeroCnt;

  always_comb begin
    rxMk     = rxPosSh | rxNegSh;
    rxDet    = (rxMk == SUB_MARKS) && (rxPosSh[4] == rxLastPol)
               && (rxPosSh[3] != rxPosSh[4]) && (rxPosSh[1] == rxPosSh[3])
               && (rxPosSh[0] != rxPosSh[1]);
    rxSubNow = rxDet || rxSubSh[7];
    rxBit    = rxMk[7] && !(cfg.b8zsEnable && rxSubNow);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxPosSh        <= 8'h00;
      rxNegSh        <= 8'h00;
      rxSubSh        <= 8'h00;
      rxLastPol      <= 1'b0;
      rxB8zsSeen     <= 1'b0;
      rxBipolarError <= 1'b0;
      rxDataOut      <= 1'b0;
    end else begin
      rxPosSh    <= {rxPosSh[6:0], rxPositiveRail};
      rxNegSh    <= {rxNegSh[6:0], rxNegativeRail};
      rxSubSh    <= rxDet ? SUB_TAIL : {rxSubSh[6:0], 1'b0};
      rxB8zsSeen <= rxDet;
      rxBipolarError <= rxMk[7] && (rxPosSh[7] == rxLastPol)
                        && !(cfg.b8zsEnable && rxSubNow);
      if (rxMk[7]) begin
        rxLastPol <= rxPosSh[7];
      end
      rxDataOut <= rxBit;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zeroCnt       <= 8'h00;
      rxCarrierLoss <= 1'b0;
    end else begin
      if (rxPositiveRail || rxNegativeRail) begin
        zeroCnt <= 8'h00;
      end else if (zeroCnt < 8'(CARRIER_ZEROS)) begin
        zeroCnt <= zeroCnt + 8'h01;
      end
      rxCarrierLoss <= (zeroCnt == 8'(CARRIER_ZEROS));
    end
  end

  // ************************************************************
  // Receive output timing and monitoring
  // ************************************************************
  tfs_state_t state;
  logic [7:0] rxBitCnt;
  logic [4:0] rxFrameCnt;
  logic [7:0] huntBit;
  logic [4:0] huntFrame;
  logic [1:0] expH;
  logic [1:0] expO;
  logic [1:0] expS;
  logic       huntBad;
  logic       huntMfEnd;
  logic       rxMfEnd;
  logic       loadNow;
  logic [3:0] errHist;
  logic       oofErr;
  logic       oofNow;
  logic       resyncPrev;
  logic       rstPrev;
  logic       startHunt;
  logic [4:0] matchCnt;
  logic [4:0] needCnt;
  logic [3:0] huntMf;
  logic [3:0] mfSince;
  logic [1:0] crcFails;
  logic [7:0] confirmCnt;
  logic [5:0] rxCrc;
  logic [5:0] rxCrcPrev;
  logic [5:0] cRecv;
  logic       fsErrMf;
  logic       fsValid;
  logic       crcDue;

  always_comb begin
    expH      = fExpect(esf, huntFrame, cfg.syncCriteria, cfg.yellowAlarmMode);
    expO      = fExpect(esf, rxFrameCnt, 1'b0, 1'b0);
    expS      = fExpect(esf, rxFrameCnt, 1'b1, cfg.yellowAlarmMode);
    huntBad   = (huntBit == 8'h00) && expH[1] && (expH[0] != rxBit);
    huntMfEnd = (huntBit == 8'(FRAME_BITS - 1))
                && (huntFrame == lastFrame(esf));
    rxMfEnd   = (rxBitCnt == 8'(FRAME_BITS - 1))
                && (rxFrameCnt == lastFrame(esf));
    loadNow   = (state == ST_LOAD) && huntMfEnd;
    oofErr    = (rxBitCnt == 8'h00) && expO[1] && (expO[0] != rxBit);
    oofNow    = ({3'h0, errHist[2]} + {3'h0, errHist[1]} + {3'h0, errHist[0]}
                 + {3'h0, oofErr}) >= 4'(OOF_LIMIT);
    needCnt   = cfg.syncTime ? 5'(SYNC_LONG) : 5'(SYNC_SHORT);
    crcDue    = (mfSince + 4'h1 >= 4'(CRC_FIRST_MF))
                && (((mfSince + 4'h1 - 4'(CRC_FIRST_MF))
                     % 4'(CRC_NEXT_MF)) == 4'h0);
    startHunt = (cfg.resync && !resyncPrev)
                || (rxResyncReset_n && !rstPrev)
                || (!cfg.syncEnable && state == ST_SYNC
                    && (oofNow || rxCarrierLoss));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      resyncPrev <= 1'b0;
      rstPrev    <= 1'b1;
    end else begin
      resyncPrev <= cfg.resync;
      rstPrev    <= rxResyncReset_n;
    end
  end

  // Output alignment counters, held while the resync reset is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxBitCnt   <= 8'h00;
      rxFrameCnt <= 5'h00;
    end else if (!rxResyncReset_n || loadNow) begin
      rxBitCnt   <= 8'h00;
      rxFrameCnt <= 5'h00;
    end else if (rxBitCnt == 8'(FRAME_BITS - 1)) begin
      rxBitCnt   <= 8'h00;
      rxFrameCnt <= rxMfEnd ? 5'h00 : rxFrameCnt + 5'h01;
    end else begin
      rxBitCnt   <= rxBitCnt + 8'h01;
    end
  end

  // Candidate counters slip one bit on every framing mismatch in ST_HUNT
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      huntBit   <= 8'h00;
      huntFrame <= 5'h00;
    end else if (!(state == ST_HUNT && huntBad)) begin
      if (huntBit == 8'(FRAME_BITS - 1)) begin
        huntBit   <= 8'h00;
        huntFrame <= huntMfEnd ? 5'h00 : huntFrame + 5'h01;
      end else begin
        huntBit   <= huntBit + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      errHist <= 4'h0;
    end else if (state != ST_SYNC) begin
      errHist <= 4'h0;
    end else if (rxBitCnt == 8'h00 && expO[1]) begin
      errHist <= {errHist[2:0], oofErr};
    end
  end

  // ************************************************************
  // Synchronizer state machine
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state        <= ST_HUNT;
      syncLossFlag <= 1'b1;
      matchCnt     <= 5'h00;
      huntMf       <= 4'h0;
      mfSince      <= 4'h0;
      crcFails     <= 2'h0;
      confirmCnt   <= 8'h00;
    end else if (startHunt) begin
      state        <= ST_HUNT;
      syncLossFlag <= 1'b1;
      matchCnt     <= 5'h00;
      huntMf       <= 4'h0;
      crcFails     <= 2'h0;
    end else begin
      case (state)
        ST_HUNT: begin
          if (huntMfEnd && huntMf != 4'hf) begin
            huntMf <= huntMf + 4'h1;
          end
          if (huntBad) begin
            matchCnt <= 5'h00;
          end else if (huntBit == 8'h00 && expH[1]) begin
            if (matchCnt + 5'h01 >= needCnt) begin
              state <= ST_LOAD;
            end
            matchCnt <= matchCnt + 5'h01;
          end
        end
        ST_LOAD: begin
          if (loadNow) begin
            mfSince    <= 4'h0;
            confirmCnt <= 8'h00;
            if (esf && (cfg.syncCriteria || huntMf >= 4'(EMUL_MF))) begin
              state <= ST_CRC;
            end else begin
              state <= ST_CONFIRM;
            end
          end
        end
        ST_CONFIRM: begin
          confirmCnt <= confirmCnt + 8'h01;
          if (confirmCnt == 8'(FRAME_BITS - 1)) begin
            syncLossFlag <= 1'b0;
            state        <= ST_SYNC;
          end
        end
        ST_CRC: begin
          if (rxMfEnd) begin
            mfSince <= mfSince + 4'h1;
            if (crcDue && cRecv == rxCrcPrev) begin
              syncLossFlag <= 1'b0;
              state        <= ST_SYNC;
            end else if (crcDue) begin
              crcFails <= crcFails + 2'h1;
              if (crcFails + 2'h1 == 2'(CRC_TRIES)) begin
                state    <= ST_HUNT;
                matchCnt <= 5'h00;
                crcFails <= 2'h0;
              end
            end
          end
        end
        default: ;
      endcase
    end
  end

  // Receive CRC-6 and collected C bits at output alignment
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxCrc     <= 6'h00;
      rxCrcPrev <= 6'h00;
      cRecv     <= 6'h00;
    end else if (rxMfEnd) begin
      rxCrc     <= 6'h00;
      rxCrcPrev <= crc6Step(rxCrc, rxBit);
    end else begin
      rxCrc <= crc6Step(rxCrc, (rxBitCnt == 8'h00) ? 1'b1 : rxBit);
      if (rxBitCnt == 8'h00 && rxFrameCnt[1:0] == 2'h1) begin
        cRecv <= {cRecv[4:0], rxBit};
      end
    end
  end

  // ************************************************************
  // Receive timing outputs
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fsErrMf             <= 1'b0;
      fsValid             <= 1'b0;
      rxSignalingFrameInd <= 1'b0;
      rxMultiframePulse   <= 1'b0;
      rxFramingErrorOut   <= 1'b0;
      rxLinkBitsOut       <= 1'b0;
    end else begin
      rxSignalingFrameInd <= !syncLossFlag && rxResyncReset_n
                             && sigFrame(esf, rxFrameCnt);
      rxMultiframePulse   <= (rxBitCnt == 8'h00) && (rxFrameCnt == 5'h00)
                             && rxResyncReset_n
                             && (esf || cfg.syncCriteria || fsValid);
      rxFramingErrorOut   <= (rxBitCnt == 8'h00) && expS[1]
                             && (expS[0] != rxBit)
                             && (esf || rxFrameCnt[0]);
      if (rxBitCnt == 8'h00 && rxFrameCnt[0] != esf) begin
        rxLinkBitsOut <= rxBit;
      end
      if (rxMfEnd) begin
        fsValid <= !fsErrMf;
        fsErrMf <= 1'b0;
      end else if (rxBitCnt == 8'h00 && rxFrameCnt[0] && expS[1]
                   && expS[0] != rxBit) begin
        fsErrMf <= 1'b1;
      end
    end
  end
endmodule // tfs_framer_sync
